/* lsrm_pkg.sv */
package lsrm_pkg;
	// ----------------------------------------------------------------
	// register locations (zero based word addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] LSRM_LOC_FAULT = 8'h04;
	localparam logic [7:0] LSRM_LOC_ADDR_FAULT = 8'h05;
	localparam logic [7:0] LSRM_LOC_PROGRESS = 8'h06;
	localparam logic [7:0] LSRM_LOC_UNITS = 8'h07;
	localparam logic [7:0] LSRM_LOC_MAP_FIRST = 8'h08;
	localparam logic [7:0] LSRM_LOC_MAP_LAST = 8'h7f;
	localparam logic [7:0] LSRM_LOC_FAIL_FIRST = 8'h80;
	localparam logic [7:0] LSRM_LOC_FAIL_LAST = 8'hf7;
	localparam logic [7:0] LSRM_LOC_FILTER = 8'hf8;
	localparam logic [7:0] LSRM_LOC_PRODUCT = 8'hf9;
	localparam logic [7:0] LSRM_LOC_CONFIG = 8'hfa;
	localparam logic [7:0] LSRM_LOC_VERSION = 8'hfb;
	localparam logic [7:0] LSRM_LOC_LOOPBACK = 8'hfc;
	localparam logic [7:0] LSRM_LOC_SPEED = 8'hfd;
	localparam logic [7:0] LSRM_LOC_RESULT = 8'hfe;
	localparam logic [7:0] LSRM_LOC_UPLOAD = 8'hff;
	// ----------------------------------------------------------------
	// field positions and codes
	// ----------------------------------------------------------------
	localparam int LSRM_BIT_PORT = 15;
	localparam int LSRM_BIT_DUP = 14;
	localparam int LSRM_BIT_HIGH = 13;
	localparam int LSRM_BIT_ZERO = 12;
	localparam logic [3:0] LSRM_FAULT_OPEN = 4'h5;
	localparam logic [3:0] LSRM_FAULT_SHORT = 4'h6;
	localparam logic [7:0] LSRM_REASON_MAX = 8'h09;
	localparam logic [7:0] LSRM_PROGRESS_MAX = 8'h09;
	localparam logic [7:0] LSRM_CAP_MAX = 8'h04;
	localparam logic [7:0] LSRM_RESULT_MAX = 8'h64;
	localparam logic [7:0] LSRM_UPLOAD_DONE = 8'hff;
	localparam logic [7:0] LSRM_SPEED_MAX = 8'h05;
	// ----------------------------------------------------------------
	// reset values, function code selectors and answer types
	// ----------------------------------------------------------------
	localparam logic [15:0] LSRM_RST_WORD = 16'h0000;
	localparam logic [7:0] LSRM_RST_COUNT = 8'h00;
	localparam logic [15:0] LSRM_RST_FILTER = 16'h003c;
	localparam logic [3:0] LSRM_SEL_READ_FC1 = 4'h1;
	localparam logic [3:0] LSRM_SEL_READ_FC3 = 4'h3;
	localparam logic [3:0] LSRM_SEL_READ_FC4 = 4'h4;
	localparam logic [3:0] LSRM_SEL_WRITE_FC6 = 4'h6;
	localparam logic [3:0] LSRM_SEL_WRITE_FC16 = 4'h0;
	typedef enum logic [1:0] {LSRM_ANS_DATA, LSRM_ANS_BAD_FC, LSRM_ANS_BAD_LOC} lsrm_ans_type;
endpackage

/* lsrm_regs.sv */
`timescale 1ns/1ns
module lsrm_regs
	import lsrm_pkg::*;
#(
	parameter int UNITS = 240,
	parameter int MODULES = 2
) (
	input wire logic CLOCK,
	input wire logic RESET_N,
	// host request: location, function code, write data
	input wire logic REQ_VALID,
	input wire logic [7:0] REQ_LOC,
	input wire logic [3:0] REQ_FUNC,
	input wire logic [15:0] REQ_WDATA,
	output logic ANS_VALID,
	output logic [1:0] ANS_CODE,
	output logic [15:0] ANS_WORD,
	output logic [7:0] ANS_HI,
	output logic [7:0] ANS_LO,
	output logic START_UPLOAD,
	// side health
	input wire logic [MODULES-1:0] MOD_FITTED,
	input wire logic [MODULES-1:0] MOD_FAULTY,
	input wire logic IS_PRIMARY,
	input wire logic STANDBY_LINK_OK,
	input wire logic STANDBY_HEALTHY,
	output logic THIS_SIDE_OK,
	output logic OTHER_SIDE_OK,
	// loop state from the loop controller
	input wire logic STAT_WE,
	input wire logic FLT_PORT,
	input wire logic FLT_DUP,
	input wire logic FLT_HIGH,
	input wire logic FLT_ZERO,
	input wire logic [3:0] FLT_TYPE,
	input wire logic [7:0] CFG_REASON,
	input wire logic [7:0] FLT_POS,
	input wire logic [7:0] FLT_ADDR,
	input wire logic [7:0] CFG_PROGRESS,
	input wire logic [7:0] COUNT_PORT_A,
	input wire logic [7:0] COUNT_PORT_B,
	input wire logic MAP_WE,
	input wire logic [7:0] MAP_IDX,
	input wire logic [7:0] MAP_ADDR,
	input wire logic FAIL_EVT,
	input wire logic [7:0] FAIL_IDX,
	input wire logic [2:0] BAUD_CODE,
	input wire logic [7:0] REDUNDANCY,
	input wire logic [7:0] CAPACITY,
	input wire logic [15:0] CARD_VERSION,
	input wire logic [7:0] LOOPBACK_X,
	input wire logic [7:0] LOOPBACK_Y,
	input wire logic [7:0] TEST_SPEED,
	input wire logic [7:0] TEST_RESULT,
	input wire logic [7:0] UPLOAD_UNIT
);
	// word decode assumes 120 words of byte pairs
	if (UNITS != 240 || MODULES < 1) begin : g_bad_params
		$error("lsrm_regs: unsupported parameters");
	end

	// ----------------------------------------------------------------
	// side health
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			THIS_SIDE_OK <= 1'b0;
			OTHER_SIDE_OK <= 1'b0;
		end else begin
			THIS_SIDE_OK <= ~|(MOD_FITTED & MOD_FAULTY);
			// an unreachable standby must never look healthy
			OTHER_SIDE_OK <= IS_PRIMARY ? (STANDBY_LINK_OK & STANDBY_HEALTHY) : 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// loop status words
	// ----------------------------------------------------------------
	logic [15:0] fault_q, addr_fault_q, progress_q, units_q, loopback_q, result_q, upload_q;
	logic [15:0] speed_q, config_q, version_q;
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			fault_q <= LSRM_RST_WORD;
			addr_fault_q <= LSRM_RST_WORD;
			progress_q <= LSRM_RST_WORD;
			units_q <= LSRM_RST_WORD;
		end else if (STAT_WE) begin
			fault_q <= {FLT_PORT, FLT_DUP, FLT_HIGH, FLT_ZERO, FLT_TYPE,
				(CFG_REASON <= LSRM_REASON_MAX) ? CFG_REASON : 8'h00};
			addr_fault_q <= {FLT_POS, FLT_ADDR};
			progress_q <= {8'h00, (CFG_PROGRESS <= LSRM_PROGRESS_MAX) ? CFG_PROGRESS : 8'h00};
			units_q <= {COUNT_PORT_B, COUNT_PORT_A};
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			loopback_q <= LSRM_RST_WORD;
			result_q <= LSRM_RST_WORD;
			upload_q <= LSRM_RST_WORD;
			speed_q <= LSRM_RST_WORD;
			config_q <= LSRM_RST_WORD;
			version_q <= LSRM_RST_WORD;
		end else begin
			loopback_q <= {LOOPBACK_Y, LOOPBACK_X};
			// out of range percentages are clamped rather than shown raw
			result_q <= {8'h00, (TEST_RESULT > LSRM_RESULT_MAX) ? LSRM_RESULT_MAX : TEST_RESULT};
			upload_q <= {8'h00, UPLOAD_UNIT};
			speed_q <= {8'h00, (TEST_SPEED <= LSRM_SPEED_MAX) ? TEST_SPEED : 8'h00};
			config_q <= {REDUNDANCY, (CAPACITY <= LSRM_CAP_MAX) ? CAPACITY : 8'h00};
			version_q <= CARD_VERSION;
		end
	end

	// ----------------------------------------------------------------
	// filter timeout default follows loop speed
	// ----------------------------------------------------------------
	logic [15:0] filter_q;
	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			filter_q <= LSRM_RST_FILTER;
		end else begin
			unique case (BAUD_CODE)
				3'h1: filter_q <= 16'h003c;
				3'h2: filter_q <= 16'h001e;
				3'h3: filter_q <= 16'h000f;
				3'h4: filter_q <= 16'h000a;
				3'h5: filter_q <= 16'h0005;
				default: filter_q <= filter_q;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// unit map and failure counters
	// ----------------------------------------------------------------
	logic [7:0] map_q [UNITS];
	logic [7:0] fail_q [UNITS];
	for (genvar i = 0; i < UNITS; i++) begin : g_unit
		always_ff @(posedge CLOCK) begin
			if (!RESET_N) begin
				map_q[i] <= LSRM_RST_COUNT;
				fail_q[i] <= LSRM_RST_COUNT;
			end else begin
				if (MAP_WE && MAP_IDX == 8'(i)) begin
					map_q[i] <= MAP_ADDR;
				end
				// a count stuck at full still means many failures
				if (FAIL_EVT && FAIL_IDX == 8'(i) && fail_q[i] != 8'hff) begin
					fail_q[i] <= fail_q[i] + 8'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// host access
	// ----------------------------------------------------------------
	logic is_read, is_write, block0, fc_ok, upload_hit;
	logic [6:0] pair;
	logic [15:0] rd_word;
	always_comb begin
		is_read = REQ_FUNC == LSRM_SEL_READ_FC1 || REQ_FUNC == LSRM_SEL_READ_FC3 ||
			REQ_FUNC == LSRM_SEL_READ_FC4;
		is_write = REQ_FUNC == LSRM_SEL_WRITE_FC6 || REQ_FUNC == LSRM_SEL_WRITE_FC16;
		block0 = REQ_LOC < LSRM_LOC_MAP_FIRST;
		fc_ok = is_write || (is_read && (block0 || REQ_FUNC != LSRM_SEL_READ_FC1));
		upload_hit = REQ_VALID && is_write && REQ_LOC == LSRM_LOC_UPLOAD &&
			REQ_WDATA != 16'h0000;
		pair = 7'h00;
		rd_word = 16'h0000;
		// location is used as given, zero based
		if (REQ_LOC >= LSRM_LOC_MAP_FIRST && REQ_LOC <= LSRM_LOC_MAP_LAST) begin
			pair = 7'(REQ_LOC - LSRM_LOC_MAP_FIRST);
			rd_word = {map_q[{pair, 1'b0}], map_q[{pair, 1'b1}]};
		end else if (REQ_LOC >= LSRM_LOC_FAIL_FIRST && REQ_LOC <= LSRM_LOC_FAIL_LAST) begin
			pair = 7'(REQ_LOC - LSRM_LOC_FAIL_FIRST);
			rd_word = {fail_q[{pair, 1'b0}], fail_q[{pair, 1'b1}]};
		end else begin
			unique case (REQ_LOC)
				LSRM_LOC_FAULT: rd_word = fault_q;
				LSRM_LOC_ADDR_FAULT: rd_word = addr_fault_q;
				LSRM_LOC_PROGRESS: rd_word = progress_q;
				LSRM_LOC_UNITS: rd_word = units_q;
				LSRM_LOC_FILTER: rd_word = filter_q;
				LSRM_LOC_PRODUCT: rd_word = 16'h0000;
				LSRM_LOC_CONFIG: rd_word = config_q;
				LSRM_LOC_VERSION: rd_word = version_q;
				LSRM_LOC_LOOPBACK: rd_word = loopback_q;
				LSRM_LOC_SPEED: rd_word = speed_q;
				LSRM_LOC_RESULT: rd_word = result_q;
				LSRM_LOC_UPLOAD: rd_word = upload_q;
				default: rd_word = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RESET_N) begin
			ANS_VALID <= 1'b0;
			ANS_CODE <= LSRM_ANS_DATA;
			ANS_WORD <= LSRM_RST_WORD;
			ANS_HI <= 8'h00;
			ANS_LO <= 8'h00;
			START_UPLOAD <= 1'b0;
		end else begin
			ANS_VALID <= REQ_VALID;
			START_UPLOAD <= REQ_VALID && is_write && REQ_LOC == LSRM_LOC_UPLOAD &&
				REQ_WDATA != 16'h0000;
			if (REQ_VALID) begin
				if (!fc_ok) begin
					ANS_CODE <= LSRM_ANS_BAD_FC;
					ANS_WORD <= 16'h0000;
				end else if (is_write && REQ_LOC != LSRM_LOC_UPLOAD) begin
					ANS_CODE <= LSRM_ANS_BAD_LOC;
					ANS_WORD <= 16'h0000;
				end else begin
					ANS_CODE <= LSRM_ANS_DATA;
					ANS_WORD <= rd_word;
				end
				ANS_HI <= fc_ok ? rd_word[15:8] : 8'h00;
				ANS_LO <= fc_ok ? rd_word[7:0] : 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_side_health: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		|(MOD_FITTED & MOD_FAULTY) |=> !THIS_SIDE_OK) else $error("side ok despite faulty module");
	chk_standby_link: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		!STANDBY_LINK_OK |=> !OTHER_SIDE_OK) else $error("standby ok without link");
	chk_fault_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		STAT_WE |=> fault_q[15:8] == $past({FLT_PORT, FLT_DUP, FLT_HIGH, FLT_ZERO, FLT_TYPE}))
		else $error("fault word layout wrong");
	chk_units_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		STAT_WE |=> units_q == {$past(COUNT_PORT_B), $past(COUNT_PORT_A)})
		else $error("unit count layout wrong");
	chk_fail_saturate: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		fail_q[0] == 8'hff |=> fail_q[0] == 8'hff) else $error("failure counter wrapped");
	chk_fail_step: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		FAIL_EVT && FAIL_IDX == 8'h00 && fail_q[0] != 8'hff |=> fail_q[0] == $past(fail_q[0]) + 8'h01)
		else $error("failure counter missed event");
	chk_result_range: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		result_q <= 16'h0064) else $error("test result above range");
	sequence upload_write_s;
		upload_hit;
	endsequence
	sequence upload_pulse_s;
		START_UPLOAD ##1 (!START_UPLOAD || $past(upload_hit));
	endsequence
	chk_upload_start: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		upload_write_s |=> upload_pulse_s)
		else $error("upload start pulse wrong");
	chk_fc1_refused: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		REQ_VALID && REQ_FUNC == LSRM_SEL_READ_FC1 && !block0 |=> ANS_CODE == LSRM_ANS_BAD_FC)
		else $error("function 1 accepted past block 0");
	chk_msb_first: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		ANS_VALID && ANS_CODE == LSRM_ANS_DATA |-> {ANS_HI, ANS_LO} == ANS_WORD)
		else $error("byte order wrong");
	chk_side_clear: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		!(|(MOD_FITTED & MOD_FAULTY)) |=> THIS_SIDE_OK)
		else $error("side not ok without faulty module");
	chk_other_standby: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		!IS_PRIMARY |=> !OTHER_SIDE_OK)
		else $error("standby side reports other side ok");
	chk_other_health: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		IS_PRIMARY && STANDBY_LINK_OK && STANDBY_HEALTHY |=> OTHER_SIDE_OK)
		else $error("healthy standby shown not ok");
	chk_fault_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		!STAT_WE |=> $stable(fault_q) && $stable(addr_fault_q) && $stable(units_q))
		else $error("status words moved without load");
	chk_reason_code: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		STAT_WE && CFG_REASON <= LSRM_REASON_MAX |=> fault_q[7:0] == $past(CFG_REASON))
		else $error("configure reason lost");
	chk_reason_clear: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		STAT_WE && CFG_REASON > LSRM_REASON_MAX |=> fault_q[7:0] == 8'h00)
		else $error("configure reason out of range shown");
	chk_addr_fault: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		STAT_WE |=> addr_fault_q == {$past(FLT_POS), $past(FLT_ADDR)})
		else $error("address fault layout wrong");
	chk_progress_code: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		STAT_WE && CFG_PROGRESS <= LSRM_PROGRESS_MAX |=>
		progress_q == {8'h00, $past(CFG_PROGRESS)}) else $error("progress code lost");
	chk_progress_clear: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		STAT_WE && CFG_PROGRESS > LSRM_PROGRESS_MAX |=> progress_q == 16'h0000)
		else $error("progress code out of range shown");
	chk_map_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		MAP_WE && MAP_IDX == 8'h00 |=> map_q[0] == $past(MAP_ADDR))
		else $error("map entry not written");
	chk_map_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		!(MAP_WE && MAP_IDX == 8'h00) |=> $stable(map_q[0]))
		else $error("map entry changed without write");
	chk_fail_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		!(FAIL_EVT && FAIL_IDX == 8'h00) |=> $stable(fail_q[0]))
		else $error("failure counter moved without event");
	chk_filter_slow: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		BAUD_CODE == 3'h1 |=> filter_q == 16'h003c)
		else $error("filter timeout wrong at slowest speed");
	chk_filter_fast: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		BAUD_CODE == 3'h5 |=> filter_q == 16'h0005)
		else $error("filter timeout wrong at fastest speed");
	chk_filter_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		BAUD_CODE == 3'h0 || BAUD_CODE > 3'h5 |=> $stable(filter_q))
		else $error("filter timeout moved on unknown speed");
	chk_config_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		CAPACITY <= LSRM_CAP_MAX |=> config_q == {$past(REDUNDANCY), $past(CAPACITY)})
		else $error("configuration word wrong");
	chk_loopback_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		$past(RESET_N) |-> loopback_q == {$past(LOOPBACK_Y), $past(LOOPBACK_X)})
		else $error("loopback word wrong");
	chk_result_track: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		$past(RESET_N) && $past(TEST_RESULT) <= LSRM_RESULT_MAX |->
		result_q == {8'h00, $past(TEST_RESULT)}) else $error("test result not shown");
	chk_upload_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		$past(RESET_N) |-> upload_q == {8'h00, $past(UPLOAD_UNIT)})
		else $error("upload progress wrong");
	chk_version_word: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		$past(RESET_N) |-> version_q == $past(CARD_VERSION))
		else $error("version word wrong");
	chk_units_read: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		REQ_VALID && is_read && fc_ok && REQ_LOC == LSRM_LOC_UNITS |=> ANS_WORD == $past(units_q))
		else $error("unit count read from wrong location");
	chk_answer_pulse: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		REQ_VALID |=> ANS_VALID) else $error("request without answer");
	chk_answer_idle: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		!REQ_VALID |=> !ANS_VALID) else $error("answer without request");
	chk_late_read: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		REQ_VALID && !block0 && (REQ_FUNC == LSRM_SEL_READ_FC3 || REQ_FUNC == LSRM_SEL_READ_FC4)
		|=> ANS_CODE == LSRM_ANS_DATA) else $error("register read refused past block 0");
	chk_bad_location: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		REQ_VALID && is_write && REQ_LOC != LSRM_LOC_UPLOAD |=>
		ANS_CODE == LSRM_ANS_BAD_LOC && !START_UPLOAD) else $error("write off upload accepted");
	chk_zero_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		REQ_VALID && REQ_WDATA == 16'h0000 |=> !START_UPLOAD)
		else $error("zero write started upload");
endmodule

/* lsrm_host.sv */
`timescale 1ns/1ns
module lsrm_host (
	input wire logic clk,
	output logic req_valid,
	output logic [7:0] req_loc,
	output logic [3:0] req_func,
	output logic [15:0] req_wdata,
	input wire logic ans_valid,
	input wire logic [1:0] ans_code,
	input wire logic [15:0] ans_word,
	input wire logic [7:0] ans_hi,
	input wire logic [7:0] ans_lo,
	input wire logic start_upload
);
	logic [15:0] got_word;
	logic [15:0] got_bytes;
	logic [3:0] got_flags;
	initial begin
		req_valid = 1'b0;
		req_loc = 8'h00;
		req_func = 4'h0;
		req_wdata = 16'h0000;
	end
	task automatic req(input logic [7:0] loc, input logic [3:0] func, input logic [15:0] wd);
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req_loc = loc;
		req_func = func;
		req_wdata = wd;
		@(posedge clk);
		#1;
		// released lines show the inverse so a stale copy is never read
		req_valid = 1'b0;
		req_loc = ~loc;
		req_func = ~func;
		req_wdata = ~wd;
		got_word = ans_word;
		got_bytes = {ans_hi, ans_lo};
		got_flags = {ans_valid, start_upload, ans_code};
	endtask
endmodule

/* loop_status_register_map_test.sv */
`timescale 1ns/1ns
module loop_status_register_map_test;
	import lsrm_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rv, av, su, so, oo, swe, fp, fd, fh, fz, mwe, fe, ip, lk, sh;
	logic [7:0] rl, rs, fpos, fadr, prg, ca, cb, mi, ma, fi, red, cap, lx, ly, spd, res, upl;
	logic [3:0] rf, ft;
	logic [15:0] rw, aw, ver;
	logic [1:0] ac, mf, mq;
	logic [7:0] ah, al;
	logic [2:0] bc;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	lsrm_regs u_dut (.CLOCK(clk), .RESET_N(rst_n), .REQ_VALID(rv), .REQ_LOC(rl), .REQ_FUNC(rf),
		.REQ_WDATA(rw), .ANS_VALID(av), .ANS_CODE(ac), .ANS_WORD(aw), .ANS_HI(ah), .ANS_LO(al),
		.START_UPLOAD(su), .MOD_FITTED(mf), .MOD_FAULTY(mq), .IS_PRIMARY(ip),
		.STANDBY_LINK_OK(lk), .STANDBY_HEALTHY(sh), .THIS_SIDE_OK(so), .OTHER_SIDE_OK(oo),
		.STAT_WE(swe), .FLT_PORT(fp), .FLT_DUP(fd), .FLT_HIGH(fh), .FLT_ZERO(fz), .FLT_TYPE(ft),
		.CFG_REASON(rs), .FLT_POS(fpos), .FLT_ADDR(fadr), .CFG_PROGRESS(prg), .COUNT_PORT_A(ca),
		.COUNT_PORT_B(cb), .MAP_WE(mwe), .MAP_IDX(mi), .MAP_ADDR(ma), .FAIL_EVT(fe), .FAIL_IDX(fi),
		.BAUD_CODE(bc), .REDUNDANCY(red), .CAPACITY(cap), .CARD_VERSION(ver), .LOOPBACK_X(lx),
		.LOOPBACK_Y(ly), .TEST_SPEED(spd), .TEST_RESULT(res), .UPLOAD_UNIT(upl));
	lsrm_host u_host (.clk(clk), .req_valid(rv), .req_loc(rl), .req_func(rf), .req_wdata(rw),
		.ans_valid(av), .ans_code(ac), .ans_word(aw), .ans_hi(ah), .ans_lo(al), .start_upload(su));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rd(input logic [7:0] loc, input logic [15:0] exp);
		u_host.req(loc, 4'h3, 16'h0000);
		chk("ans_word", exp, u_host.got_word);
		chk("ans_bytes", exp, u_host.got_bytes);
	endtask
	task automatic cyc_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic t_reset;
		rd(LSRM_LOC_FILTER, 16'h003c);
		rd(8'h00, 16'h0000);
		rd(LSRM_LOC_UPLOAD, 16'h0000);
		$display("test reset done");
	endtask
	task automatic t_fault;
		{fp, fd, fh, fz, ft, rs, fpos, fadr} = {4'b1101, 4'h5, 8'h09, 8'h17, 8'h00};
		{prg, ca, cb, swe} = {8'h09, 8'h21, 8'h12, 1'b1};
		cyc_n(1);
		swe = 1'b0;
		rd(LSRM_LOC_FAULT, 16'hd509);
		rd(LSRM_LOC_ADDR_FAULT, 16'h1700);
		rd(LSRM_LOC_PROGRESS, 16'h0009);
		rd(LSRM_LOC_UNITS, 16'h1221);
		{fp, fd, fh, fz, ft, rs, prg, swe} = {4'b0010, 4'h6, 8'h0a, 8'h0a, 1'b1};
		cyc_n(1);
		swe = 1'b0;
		rd(LSRM_LOC_FAULT, 16'h2600);
		rd(LSRM_LOC_PROGRESS, 16'h0000);
		$display("test fault words done");
	endtask
	task automatic t_units;
		{mwe, mi, ma} = {1'b1, 8'h00, 8'h2a};
		cyc_n(1);
		{mi, ma} = {8'hef, 8'h3c};
		cyc_n(1);
		{mwe, fe, fi} = {1'b0, 1'b1, 8'h00};
		cyc_n(260);
		fi = 8'hef;
		cyc_n(1);
		fe = 1'b0;
		rd(LSRM_LOC_MAP_FIRST, 16'h2a00);
		rd(LSRM_LOC_MAP_LAST, 16'h003c);
		rd(LSRM_LOC_FAIL_FIRST, 16'hff00);
		rd(LSRM_LOC_FAIL_LAST, 16'h0001);
		$display("test unit tables done");
	endtask
	task automatic t_block31;
		logic [7:0] secs [5] = '{8'h3c, 8'h1e, 8'h0f, 8'h0a, 8'h05};
		for (int i = 0; i < 5; i++) begin
			bc = 3'(i + 1);
			cyc_n(2);
			rd(LSRM_LOC_FILTER, {8'h00, secs[i]});
		end
		{red, cap, ver, lx, ly, res, upl} = {8'h02, 8'h04, 16'h0156, 8'h03, 8'h07, 8'h64, 8'hff};
		spd = 8'h05;
		cyc_n(2);
		rd(LSRM_LOC_SPEED, 16'h0005);
		rd(LSRM_LOC_PRODUCT, 16'h0000);
		rd(LSRM_LOC_CONFIG, 16'h0204);
		rd(LSRM_LOC_VERSION, 16'h0156);
		rd(LSRM_LOC_LOOPBACK, 16'h0703);
		rd(LSRM_LOC_RESULT, 16'h0064);
		rd(LSRM_LOC_UPLOAD, 16'h00ff);
		{cap, lx, res, upl, spd} = {8'h05, 8'h00, 8'h65, 8'h2b, 8'h06};
		cyc_n(2);
		rd(LSRM_LOC_SPEED, 16'h0000);
		rd(LSRM_LOC_CONFIG, 16'h0200);
		rd(LSRM_LOC_LOOPBACK, 16'h0700);
		rd(LSRM_LOC_RESULT, 16'h0064);
		rd(LSRM_LOC_UPLOAD, 16'h002b);
		$display("test block 31 done");
	endtask
	task automatic t_func;
		// flags: answer valid, upload start, answer code
		logic [7:0] loc [8] = '{8'h04, 8'h08, 8'h04, 8'hff, 8'hff, 8'h04, 8'hff, 8'h80};
		logic [3:0] fn [8] = '{4'h1, 4'h1, 4'h2, 4'h6, 4'h6, 4'h6, 4'h0, 4'h4};
		logic [15:0] wd [8] = '{16'h0, 16'h0, 16'h0, 16'h0001, 16'h0000,
			16'h0001, 16'hff00, 16'h0};
		logic [3:0] ex [8] = '{4'h8, 4'h9, 4'h9, 4'hc, 4'h8, 4'ha, 4'hc, 4'h8};
		for (int i = 0; i < 8; i++) begin
			u_host.req(loc[i], fn[i], wd[i]);
			chk("ans_flags", {12'h000, ex[i]}, {12'h000, u_host.got_flags});
		end
		$display("test function codes done");
	endtask
	task automatic t_health;
		{mf, mq, ip, lk, sh} = {2'b10, 2'b01, 3'b111};
		cyc_n(2);
		chk("side_ok", 16'h0003, {14'h0, so, oo});
		{mf, lk} = {2'b11, 1'b0};
		cyc_n(2);
		chk("side_ok", 16'h0000, {14'h0, so, oo});
		{mq, lk, ip} = {2'b00, 1'b1, 1'b0};
		cyc_n(2);
		chk("side_ok", 16'h0002, {14'h0, so, oo});
		{ip, sh} = 2'b10;
		cyc_n(2);
		chk("side_ok", 16'h0002, {14'h0, so, oo});
		sh = 1'b1;
		cyc_n(2);
		chk("side_ok", 16'h0003, {14'h0, so, oo});
		$display("test side health done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// hang guard: the full run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			complete_run();
		end
	end
	initial begin
		{swe, fp, fd, fh, fz, ft, rs, fpos, fadr, prg, ca, cb} = '0;
		{mwe, mi, ma, fe, fi, bc, red, cap, ver, lx, ly, spd, res, upl} = '0;
		{mf, mq, ip, lk, sh} = '0;
		cyc_n(2);
		rst_n = 1'b1;
		t_reset();
		t_fault();
		t_units();
		t_block31();
		t_func();
		t_health();
		complete_run();
	end
endmodule
